//--- logic/ifw_fetch_watch_timer.sv
`timescale 1ns/1ps
// What this block does
// - runs only on the system clock
// - counts one per reported fetch, else holds
// - free-runs without reload until match, then stops
// - raises interrupt request on count match
// - holds count while core sleeps
// - runs if fuse enable or software enable
// - 32-bit counter against 32-bit match
// - match built from two 16-bit words
// - instantiated on primary core only
module ifw_fetch_watch_timer
   import ifw_pkg::*;
#(
   parameter int CNT_W = IFW_CNT_W
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire ifw_fetch_s           core_fetch,
   input  wire ifw_match_s           match_words,
   input  wire logic                 fuse_enable,
   input  wire logic                 fetch_timer_control_on,
   output logic                      irq,
   output logic [CNT_W-1:0]          count,
   output logic                      running
);

   // this module is placed only in the primary core's subsystem

   // the match value is handled as equal 16-bit halves
   localparam int N_HALF = CNT_W / IFW_HALF_W;

   ifw_state_e              state;
   ifw_state_e              next_state;
   logic                    fuse_enable_sync;
   logic                    enabled;
   logic                    fetch_ok;
   logic                    in_run;
   logic                    frozen;
   logic                    step_en;
   logic                    hit;
   logic [N_HALF-1:0]       half_hit;
   logic [IFW_HALF_W-1:0]   half_match [N_HALF];
   logic [IFW_HALF_W-1:0]   half_count [N_HALF];
   logic [CNT_W-1:0]        match_value;
   logic [CNT_W-1:0]        next_count;
   logic                    next_irq;
   logic                    next_running;
   ifw_match_s              match_q;

   // fuse level comes from the configuration block, treated as asynchronous
   ifw_sync #(
      .W (1)
   ) u_fuse_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (fuse_enable),
      .q     (fuse_enable_sync)
   );

   // registered copy of the configuration words; they are static after load
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         match_q <= '{IFW_WORD_RST, IFW_WORD_RST};
      end else begin
         match_q <= match_words;
      end
   end

   always_comb begin
      match_value = '0;
      match_value[IFW_LO_LSB +: IFW_HALF_W] = match_q.match_count_low_word;
      match_value[IFW_HI_LSB +: IFW_HALF_W] = match_q.match_count_high_word;
   end

   // fuse path is two cycles late; the control bit acts on the next edge
   assign enabled  = fuse_enable_sync | fetch_timer_control_on;

   // a sleeping core fetches nothing; sleep also masks a stray fetch flag
   assign fetch_ok = core_fetch.fetch & ~core_fetch.sleep;

   // compare half by half so each equality tree stays one word wide
   for (genvar h = 0; h < N_HALF; h++) begin : g_half
      assign half_match[h] = match_value[h*IFW_HALF_W +: IFW_HALF_W];
      assign half_count[h] = count[h*IFW_HALF_W +: IFW_HALF_W];
      assign half_hit[h]   = (half_count[h] == half_match[h]);
   end

   assign hit = &half_hit;

   // counting needs the run state, no match yet and a real fetch
   assign step_en = in_run & ~frozen & ~hit & fetch_ok;

   always_comb begin
      next_state = state;
      case (state)
         // the enable only arms the timer; dropping it later changes nothing
         IFW_IDLE: begin
            if (enabled) begin
               next_state = IFW_RUN;
            end
         end
         IFW_RUN: begin
            if (hit) begin
               next_state = IFW_MATCHED;
            end
         end
         // no way out but reset, so a hung program cannot re-arm it
         IFW_MATCHED: begin
            next_state = IFW_MATCHED;
         end
         // unused encoding falls back to idle
         default: begin
            next_state = IFW_IDLE;
         end
      endcase
   end

   // all state is on clk alone; no separate timer clock exists
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= IFW_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // one place that says what each state permits
   always_comb begin
      in_run = 1'b0;
      frozen = 1'b0;
      case (state)
         IFW_IDLE: begin
            in_run = 1'b0;
            frozen = 1'b0;
         end
         IFW_RUN: begin
            in_run = 1'b1;
            frozen = 1'b0;
         end
         IFW_MATCHED: begin
            in_run = 1'b0;
            frozen = 1'b1;
         end
         default: begin
            in_run = 1'b0;
            frozen = 1'b1;
         end
      endcase
   end

   // no reload path exists: the count only ever steps upward
   always_comb begin
      next_count = count;
      if (step_en) begin
         next_count = count + CNT_W'(IFW_CNT_STEP);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count <= CNT_W'(IFW_CNT_RST);
      end else begin
         count <= next_count;
      end
   end

   // a match seen while running latches the request
   always_comb begin
      next_irq = irq;
      if (in_run && hit) begin
         next_irq = 1'b1;
      end
   end

   // request stays asserted until reset: a malfunction is not self-healing
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   // running is registered from next_state, so it matches the current run state
   assign next_running = (next_state == IFW_RUN);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         running <= 1'b0;
      end else begin
         running <= next_running;
      end
   end

endmodule

//--- logic/ifw_pkg.sv
package ifw_pkg;

   localparam int          IFW_CNT_W      = 32;
   localparam int          IFW_HALF_W     = 16;
   localparam logic [31:0] IFW_CNT_RST    = 32'h0000_0000;
   localparam logic [31:0] IFW_CNT_STEP   = 32'h0000_0001;
   localparam logic [15:0] IFW_WORD_RST   = 16'h0000;
   localparam int          IFW_LO_LSB     = 0;
   localparam int          IFW_HI_LSB     = 16;
   localparam int          IFW_SYNC_DEPTH = 2;

   typedef enum logic [1:0] {
      IFW_IDLE,
      IFW_RUN,
      IFW_MATCHED
   } ifw_state_e;

   // the two non-volatile halves that make up the match value
   typedef struct packed {
      logic [15:0] match_count_high_word;
      logic [15:0] match_count_low_word;
   } ifw_match_s;

   // per-cycle report from the core fetch path
   typedef struct packed {
      logic fetch;
      logic sleep;
   } ifw_fetch_s;

endpackage

//--- logic/ifw_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for the configuration enable level
module ifw_sync
   import ifw_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

//--- verification/ifw_checker.sv
`timescale 1ns/1ps
module ifw_checker
   import ifw_pkg::*;
#(parameter int CNT_W = IFW_CNT_W) (
   input wire logic             clk,
   input wire logic             rst_n,
   input wire ifw_fetch_s       core_fetch,
   input wire ifw_match_s       match_words,
   input wire logic             fuse_enable,
   input wire logic             fetch_timer_control_on,
   input wire logic             irq,
   input wire logic [CNT_W-1:0] count,
   input wire logic             running
);
   wire take = core_fetch.fetch & ~core_fetch.sleep;
   wire hit  = (count == match_words);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_armed; running && take && !hit; endsequence
   AST_STEP: assert property (s_armed |=> count == $past(count) + 1)
      else $error("count did not step");
   AST_HOLD: assert property (!take |=> $stable(count))
      else $error("count moved without fetch");
   AST_SLEEP: assert property (core_fetch.sleep |=> $stable(count))
      else $error("count moved in sleep");
   AST_STOP: assert property (hit |=> $stable(count))
      else $error("count moved past match");
   AST_IRQ: assert property (running && hit |=> irq)
      else $error("no irq on match");
   AST_STICKY: assert property (irq |=> irq)
      else $error("irq dropped");
   AST_NOIRQ: assert property (!irq && !hit |=> !irq)
      else $error("irq without match");
   AST_EN: assert property (fetch_timer_control_on ##1 !running |=> running || irq)
      else $error("software enable ignored");
   AST_RST: assert property (disable iff (1'b0) !rst_n |=> count == '0 && !irq)
      else $error("reset did not clear");
endmodule
bind ifw_fetch_watch_timer ifw_checker #(.CNT_W(CNT_W)) chk_u (.clk, .rst_n, .core_fetch,
   .match_words, .fuse_enable, .fetch_timer_control_on, .irq, .count, .running);

//--- verification/ifw_core_model.sv
`timescale 1ns/1ps
// fetch path: one fetch per cycle while go, none while asleep
module ifw_core_model
   import ifw_pkg::*;
(
   input  wire logic go,
   input  wire logic nap,
   output ifw_fetch_s core_fetch
);
   assign core_fetch = '{fetch: go & ~nap, sleep: nap};
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import ifw_pkg::*;
   logic        clk = 0, rst_n = 0, fuse = 0, on = 0, go = 0, nap = 0, irq, running;
   ifw_match_s  mw = '0;
   ifw_fetch_s  cf;
   logic [31:0] count;
   int          n_fail = 0, n_compared = 0, cyc = 0;
   always #2 clk = ~clk;
   ifw_core_model core_u (.go(go), .nap(nap), .core_fetch(cf));
   ifw_fetch_watch_timer dut_u (.clk(clk), .rst_n(rst_n), .core_fetch(cf),
      .match_words(mw), .fuse_enable(fuse), .fetch_timer_control_on(on),
      .irq(irq), .count(count), .running(running));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task rst();
      rst_n = 0;
      repeat (5) @(negedge clk);
      rst_n = 1;
   endtask
   task cyc_n(input int n);
      repeat (n) @(negedge clk);
   endtask
   task t_sw();
      mw = '{match_count_high_word: 16'h0000, match_count_low_word: 16'h0005};
      on = 1;
      rst();
      go = 1; nap = 1; cyc_n(3);
      chk(count, 0);
      chk(running, 1);
      nap = 0; cyc_n(2);
      chk(count, 2);
      go = 0; cyc_n(3);
      chk(count, 2);
      go = 1; cyc_n(8);
      chk(count, 5);
      chk(irq, 1);
      chk(running, 0);
      $display("software enable test done");
   endtask
   task t_fuse();
      // high word set so the match needs the upper half to count
      on = 0; go = 1;
      mw = '{match_count_high_word: 16'h0001, match_count_low_word: 16'h0002};
      rst(); cyc_n(4);
      chk(count, 0);
      chk(running, 0);
      fuse = 1;
      for (int i = 0; i < 70000 && irq !== 1'b1; i++) cyc_n(1);
      chk(count, 32'h0001_0002);
      rst();
      chk(count, 0);
      $display("fuse enable test done");
   endtask
   task conclude();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk) if (++cyc > 90000) begin
      n_fail++;
      conclude();
   end
   initial begin
      t_sw();
      t_fuse();
      conclude();
   end
endmodule
